// ===== rtl/nvw_pkg.sv
// Operation
// R1: a new row is opened only by select falling or address bits 16..2 changing
// R2: device holds 128K words of 16 bits; row is bits 16..2, column bits 1..0
// R3: after select rises, keep it high for the minimum precharge time
// R4: one write strobe pulse low then high for every word written
// R5: select falling latches the address; strobe high makes it a read
// R6: random accesses to other rows are spaced by the random cycle time
// R7: device drives data only with output drive and a byte select low
// R8: device keeps data undriven until the read access has completed
// R9: output drive high keeps every data line undriven by the device
// R10: strobe low at select fall makes a write; device never drives then
// R11: strobe falling after select turns a read into a write and floats data
// R12: write runs from strobe fall to first rise; data held stable meanwhile
// R13: changing only column bits gives the new word within the page access time
// R14: further strobe pulses with new column while selected write into the open row
// R15: a row change closes the row, then new data arrives within address access time
// R16: finish accesses before sleep; wait the sleep exit delay after waking
// R17: eight protect bits, one per 16K sector, block writes when set
// R18: protect entry needs six exact reads, each returning array data
// R19: first write after the six reads carries the pending protect byte
// R20: next write carries its complement, else the sequence restarts
// R21: wrong address or a seventh read resets the protect sequence
// R22: host issues six reads, three writes and a closing read of address zero
// R23: each strobe fall latches the column address of a page write
// R24: writes to a protected sector leave it unchanged, bus cycle completes
package nvw_pkg;

   // ==========================================
   // timing, all figures in ns at a 10 ns clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDRESS_ACCESS_TIME_NS = 70;
   localparam int PAGE_ACCESS_TIME_NS = 30;
   localparam int MIN_PRECHARGE_TIME_NS = 70;
   localparam int RANDOM_READ_CYCLE_TIME_NS = 130;
   localparam int RANDOM_WRITE_CYCLE_TIME_NS = 130;
   localparam int WRITE_PULSE_TIME_NS = 70;
   localparam int SLEEP_EXIT_DELAY_NS = 450;
   // least times, so round up
   localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAGE_CYC = (PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHARGE_CYC = (MIN_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYCLE_CYC = (RANDOM_READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLE_CYC = (RANDOM_WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================
   // address layout and protect sequence
   localparam int ADDR_BITS = 17;
   localparam int DATA_BITS = 16;
   localparam int ROW_LSB = 2;
   localparam int SECTOR_LSB = 14;
   localparam logic [3:0] WP_LAST_STEP = 4'h9;
   localparam logic [3:0] WP_BYTE_STEP = 4'h6;
   localparam logic [3:0] WP_CPL_STEP = 4'h7;
   localparam logic [3:0] WP_TAIL_STEP = 4'h8;
   localparam logic [1:0] BYTES_ALL_N = 2'h0;
   localparam logic [1:0] BYTES_NONE_N = 2'h3;

   typedef enum logic [3:0] {
      NVW_IDLE, NVW_OPEN, NVW_READ, NVW_WR_SETUP, NVW_WR_PULSE,
      NVW_WR_HOLD, NVW_PRECH, NVW_SLEEP, NVW_WAKE
   } nvw_state_t;

   function automatic logic [16:0] nvw_wp_addr(input logic [3:0] step);
      case (step)
         4'h0: nvw_wp_addr = 17'h12555;
         4'h1: nvw_wp_addr = 17'h1daaa;
         4'h2: nvw_wp_addr = 17'h01333;
         4'h3: nvw_wp_addr = 17'h0eccc;
         4'h4: nvw_wp_addr = 17'h000ff;
         4'h5: nvw_wp_addr = 17'h1ff00;
         4'h6: nvw_wp_addr = 17'h1daaa;
         4'h7: nvw_wp_addr = 17'h0eccc;
         4'h8: nvw_wp_addr = 17'h0ff00;
         default: nvw_wp_addr = 17'h00000;
      endcase
   endfunction

   function automatic logic nvw_wp_is_write(input logic [3:0] step);
      nvw_wp_is_write = (step == WP_BYTE_STEP) || (step == WP_CPL_STEP) || (step == WP_TAIL_STEP);
   endfunction

endpackage

// ===== rtl/nvw_host_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module nvw_host_ctrl import nvw_pkg::*; #(
   parameter int AW = ADDR_BITS,
   parameter int DW = DATA_BITS
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_REQ,
   input wire logic I_WE,
   input wire logic [AW-1:0] I_ADDR,
   input wire logic [DW-1:0] I_WDATA,
   input wire logic [1:0] I_BE_N,
   input wire logic I_SLEEP,
   input wire logic I_WP_REQ,
   input wire logic [7:0] I_WP_BYTE,
   input wire logic [DW-1:0] I_DATA_LINES,
   output logic O_READY,
   output logic O_RVALID,
   output logic [DW-1:0] O_RDATA,
   output logic O_WP_BUSY,
   output logic O_CHIP_SELECT_N,
   output logic O_WRITE_STROBE_N,
   output logic O_OUTPUT_DRIVE_N,
   output logic O_UPPER_BYTE_SEL_N,
   output logic O_LOWER_BYTE_SEL_N,
   output logic O_SLEEP_REQUEST_N,
   output logic [AW-1:0] O_ADDR,
   output logic [DW-1:0] O_DATA_LINES_O,
   output logic O_DATA_LINES_OE
);

   // ==========================================
   // command source: user port or protect sequencer
   nvw_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next, rc_reg, rc_next;
   logic pend_reg, pend_next, we_reg, issue, done, row_start, start_we;
   logic wp_act_reg, wp_act_next, wp_start;
   logic [3:0] wp_step_reg;
   logic [7:0] wp_byte_reg;
   logic [1:0] be_reg, be_next;
   logic [DW-1:0] wd_reg;
   logic cur_we, issue_req, page_hit, ready_reg;
   logic [AW-1:0] cur_addr;
   logic [DW-1:0] cur_wdata;
   logic [1:0] cur_be;

   always_comb begin
      cur_we = wp_act_reg ? nvw_wp_is_write(wp_step_reg) : I_WE;
      cur_addr = wp_act_reg ? AW'(nvw_wp_addr(wp_step_reg)) : I_ADDR;
      cur_be = wp_act_reg ? BYTES_ALL_N : I_BE_N;
      cur_wdata = I_WDATA;
      if (wp_act_reg) begin
         if (wp_step_reg == WP_BYTE_STEP) begin
            cur_wdata = DW'(wp_byte_reg); // R19
         end else if (wp_step_reg == WP_CPL_STEP) begin
            cur_wdata = DW'(~wp_byte_reg); // R20
         end else begin
            cur_wdata = '0;
         end
      end
   end

   assign issue_req = (ready_reg && I_REQ) || wp_act_reg;
   assign page_hit = cur_addr[AW-1:ROW_LSB] == O_ADDR[AW-1:ROW_LSB]; // R2
   assign wp_start = state_reg == NVW_IDLE && ready_reg && I_WP_REQ && !I_REQ;

   // ==========================================
   // access sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = (cnt_reg != 8'h0) ? cnt_reg - 8'h1 : 8'h0;
      rc_next = (rc_reg != 8'h0) ? rc_reg - 8'h1 : 8'h0;
      pend_next = pend_reg;
      issue = 1'b0;
      done = 1'b0;
      row_start = 1'b0;
      start_we = we_reg;
      case (state_reg)
         NVW_IDLE: begin
            if (issue_req) begin
               issue = 1'b1;
               row_start = 1'b1; // R5
               start_we = cur_we;
               state_next = cur_we ? NVW_WR_SETUP : NVW_READ;
               cnt_next = 8'(ACCESS_CYC - 1);
            end else if (ready_reg && I_SLEEP && !I_WP_REQ) begin
               state_next = NVW_SLEEP; // R16
            end
         end
         NVW_OPEN: begin
            if (issue_req && page_hit) begin
               issue = 1'b1; // R13 R14
               state_next = cur_we ? NVW_WR_SETUP : NVW_READ;
               cnt_next = 8'(PAGE_CYC - 1);
            end else if (issue_req || (ready_reg && (I_SLEEP || I_WP_REQ))) begin
               issue = issue_req; // R15
               pend_next = issue_req;
               state_next = NVW_PRECH;
               cnt_next = 8'(PRECHARGE_CYC - 1);
            end
         end
         NVW_READ: begin
            if (cnt_reg == 8'h0) begin
               done = 1'b1; // R8
               state_next = wp_act_reg ? NVW_PRECH : NVW_OPEN;
               cnt_next = 8'(PRECHARGE_CYC - 1);
            end
         end
         NVW_WR_SETUP: begin
            state_next = NVW_WR_PULSE; // R11
            cnt_next = 8'(WRITE_PULSE_CYC - 1);
         end
         NVW_WR_PULSE: begin
            if (cnt_reg == 8'h0) begin
               state_next = NVW_WR_HOLD; // R4 R12
            end
         end
         NVW_WR_HOLD: begin
            done = 1'b1; // R24
            state_next = wp_act_reg ? NVW_PRECH : NVW_OPEN;
            cnt_next = 8'(PRECHARGE_CYC - 1);
         end
         NVW_PRECH: begin
            if (cnt_reg == 8'h0 && rc_reg == 8'h0) begin // R3 R6
               if (pend_reg) begin
                  pend_next = 1'b0;
                  row_start = 1'b1; // R1
                  state_next = we_reg ? NVW_WR_SETUP : NVW_READ;
                  cnt_next = 8'(ACCESS_CYC - 1);
               end else begin
                  state_next = NVW_IDLE;
               end
            end
         end
         NVW_SLEEP: begin
            if (!I_SLEEP) begin
               state_next = NVW_WAKE;
               cnt_next = 8'(SLEEP_EXIT_CYC - 1);
            end
         end
         NVW_WAKE: begin
            if (cnt_reg == 8'h0) begin
               state_next = NVW_IDLE; // R16
            end
         end
         default: state_next = NVW_IDLE;
      endcase
      if (row_start) begin
         rc_next = start_we ? 8'(WRITE_CYCLE_CYC - 1) : 8'(READ_CYCLE_CYC - 1);
      end
      be_next = issue ? cur_be : be_reg;
   end

   always_comb begin
      wp_act_next = wp_act_reg;
      if (wp_start) begin
         wp_act_next = 1'b1;
      end else if (done && wp_act_reg && wp_step_reg == WP_LAST_STEP) begin
         wp_act_next = 1'b0; // R22
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         state_reg <= NVW_IDLE;
         cnt_reg <= 8'h0;
         rc_reg <= 8'h0;
         pend_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         rc_reg <= rc_next;
         pend_reg <= pend_next;
         ready_reg <= (state_next == NVW_IDLE || state_next == NVW_OPEN) && !wp_act_next; // R21
      end
   end

   // ==========================================
   // protect sequencer; one select cycle per step so every step is a fresh row
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wp_act_reg <= 1'b0;
         wp_step_reg <= 4'h0;
         wp_byte_reg <= 8'h0;
      end else begin
         wp_act_reg <= wp_act_next;
         if (wp_start) begin
            wp_step_reg <= 4'h0; // R18
            wp_byte_reg <= I_WP_BYTE; // R17
         end else if (done && wp_act_reg) begin
            wp_step_reg <= wp_step_reg + 4'h1;
         end
      end
   end

   // ==========================================
   // command latch loaded on issue; control pins registered from the next state
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_ADDR <= '0;
         wd_reg <= '0;
         we_reg <= 1'b0;
         be_reg <= BYTES_NONE_N;
      end else if (issue) begin
         O_ADDR <= cur_addr; // R23
         wd_reg <= cur_wdata;
         we_reg <= cur_we;
         be_reg <= cur_be;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_CHIP_SELECT_N <= 1'b1;
         O_WRITE_STROBE_N <= 1'b1;
         O_OUTPUT_DRIVE_N <= 1'b1;
         O_UPPER_BYTE_SEL_N <= 1'b1;
         O_LOWER_BYTE_SEL_N <= 1'b1;
         O_SLEEP_REQUEST_N <= 1'b1;
         O_DATA_LINES_O <= '0;
         O_DATA_LINES_OE <= 1'b0;
      end else begin
         O_CHIP_SELECT_N <= !(state_next inside {NVW_OPEN, NVW_READ, NVW_WR_SETUP, NVW_WR_PULSE, NVW_WR_HOLD});
         O_WRITE_STROBE_N <= state_next != NVW_WR_PULSE; // R4
         // output drive stays high on writes so the device never fights us
         O_OUTPUT_DRIVE_N <= state_next != NVW_READ; // R7 R9 R10
         O_UPPER_BYTE_SEL_N <= (state_next inside {NVW_READ, NVW_WR_SETUP, NVW_WR_PULSE, NVW_WR_HOLD}) ? be_next[1] : 1'b1;
         O_LOWER_BYTE_SEL_N <= (state_next inside {NVW_READ, NVW_WR_SETUP, NVW_WR_PULSE, NVW_WR_HOLD}) ? be_next[0] : 1'b1;
         O_SLEEP_REQUEST_N <= state_next != NVW_SLEEP;
         O_DATA_LINES_O <= issue ? cur_wdata : wd_reg;
         O_DATA_LINES_OE <= state_next inside {NVW_WR_SETUP, NVW_WR_PULSE, NVW_WR_HOLD}; // R12
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_RDATA <= '0;
         O_RVALID <= 1'b0;
         O_READY <= 1'b0;
         O_WP_BUSY <= 1'b0;
      end else begin
         O_RVALID <= done && state_reg == NVW_READ && !wp_act_reg;
         if (done && state_reg == NVW_READ) begin
            O_RDATA <= I_DATA_LINES;
         end
         O_READY <= (state_next == NVW_IDLE || state_next == NVW_OPEN) && !wp_act_next;
         O_WP_BUSY <= wp_act_next;
      end
   end

   // ==========================================
   // checks
   sequence cs_held_high;
      O_CHIP_SELECT_N [*7];
   endsequence
   sequence strobe_pulse;
      !O_WRITE_STROBE_N [*7] ##1 O_WRITE_STROBE_N;
   endsequence

   precharge_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R3
      $rose(O_CHIP_SELECT_N) |-> cs_held_high) else $error("select high shorter than precharge");
   strobe_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R4
      $fell(O_WRITE_STROBE_N) |-> strobe_pulse) else $error("write strobe pulse wrong length");
   drive_selected_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R5
      !O_OUTPUT_DRIVE_N |-> !O_CHIP_SELECT_N && O_WRITE_STROBE_N) else $error("output drive without read");
   no_contention_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R10
      O_DATA_LINES_OE |-> O_OUTPUT_DRIVE_N) else $error("host and device drive together");
   write_data_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R12
      !O_WRITE_STROBE_N |-> O_DATA_LINES_OE && $stable(O_DATA_LINES_O)) else $error("write data not held");
   row_stable_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R1
      !O_CHIP_SELECT_N && !$past(O_CHIP_SELECT_N) |-> $stable(O_ADDR[AW-1:ROW_LSB])) else $error("row changed");
   random_space_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R6
      $fell(O_CHIP_SELECT_N) |-> ##1 ((!$fell(O_CHIP_SELECT_N)) throughout (##11 1'b1))) else $error("random too soon");
   sleep_exit_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R16
      $rose(O_SLEEP_REQUEST_N) |-> O_CHIP_SELECT_N throughout (##44 1'b1)) else $error("access before wake");
   sleep_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R16
      !O_SLEEP_REQUEST_N |-> O_CHIP_SELECT_N && O_WRITE_STROBE_N) else $error("access during sleep");
   wp_complement_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R20
      wp_act_reg && wp_step_reg == WP_CPL_STEP && !O_WRITE_STROBE_N |-> O_DATA_LINES_O[7:0] == ~wp_byte_reg)
      else $error("protect complement wrong");

endmodule
`default_nettype wire

// ===== rtl/nvw_placeholder_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== verification/nvw_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module nvw_dev_model import nvw_pkg::*; #(
   parameter int ACC_NS = 60,
   parameter int PAGE_NS = 25
) (
   input wire logic i_cs_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic i_upper_sel_n,
   input wire logic i_lower_sel_n,
   input wire logic i_sleep_n,
   input wire logic [16:0] i_addr,
   input wire logic [15:0] i_dq,
   output var logic [15:0] o_dq,
   output var logic [1:0] o_dq_oe,
   output var int o_viol
);
   // ====================
   // array and protect state
   localparam logic [16:0] SEQ [6] = '{17'h12555, 17'h1daaa, 17'h01333, 17'h0eccc, 17'h000ff, 17'h1ff00};
   logic [15:0] mem [int];
   logic [7:0] prot = 8'h00;
   logic [7:0] pend = 8'h00;
   logic [16:0] cur_a = 17'h00000;
   logic [16:0] wr_a = 17'h00000;
   logic valid = 1'b0;
   logic sel = 1'b0;
   logic wrote = 1'b0;
   logic slept = 1'b0;
   int step = 0;
   int gen = 0;
   realtime t_rise = -1000.0;
   realtime t_fall = -1000.0;
   realtime t_wake = -1000.0;
   initial o_viol = 0;
   initial o_dq = 16'h0000;
   function automatic logic [15:0] rd(input logic [16:0] a);
      return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a5a;
   endfunction
   // stale completions are dropped by the generation count
   task automatic start(input int ns);
      int g;
      gen++;
      g = gen;
      valid = 1'b0;
      fork
         #(ns) if (g == gen) begin
            o_dq = rd(cur_a);
            valid = 1'b1;
         end
      join_none
   endtask
   task automatic wp_event(input logic wr, input logic [16:0] a, input logic [7:0] d, output logic skip);
      skip = 1'b0;
      if (step < 6 && !wr && a == SEQ[step]) step++;
      else if (step == 6 && wr) begin
         pend = d;
         skip = 1'b1;
         step = 7;
      end else if (step == 7 && wr) begin
         if (d == ~pend) prot = pend;
         step = 0;
      end else step = (!wr && a == SEQ[0]) ? 1 : 0;
   endtask
   task automatic close_rd();
      logic s;
      if (!wrote) wp_event(1'b0, cur_a, 8'h00, s);
   endtask
   task automatic finish_wr();
      logic s;
      logic [15:0] old;
      wrote = 1'b1;
      wp_event(1'b1, wr_a, i_dq[7:0], s);
      old = rd(wr_a);
      if (!s && !prot[wr_a[16:14]]) mem[wr_a] = {i_upper_sel_n ? old[15:8] : i_dq[15:8], i_lower_sel_n ? old[7:0] : i_dq[7:0]};
      o_dq = rd(cur_a);
   endtask
   task automatic open_row();
      cur_a = i_addr;
      wr_a = i_addr;
      wrote = 1'b0;
      start(ACC_NS);
   endtask
   // ====================
   // pin events other than the sleep pin, all ignored while asleep
   always @(negedge i_cs_n) if (i_sleep_n) begin
      if ($realtime - t_rise < MIN_PRECHARGE_TIME_NS) o_viol++;
      if ($realtime - t_fall < RANDOM_READ_CYCLE_TIME_NS) o_viol++;
      if ($realtime - t_wake < SLEEP_EXIT_DELAY_NS) o_viol++;
      t_fall = $realtime;
      // host moves address and select on one edge; latch once both have settled
      #1;
      sel = 1'b1;
      open_row();
   end
   always @(i_addr) begin
      #1;
      if (sel && i_sleep_n && i_addr != cur_a) begin
         if (i_addr[16:2] != cur_a[16:2]) begin
            close_rd();
            open_row();
         end else begin
            cur_a = i_addr;
            start(PAGE_NS);
         end
      end
   end
   always @(negedge i_we_n) if (sel && i_sleep_n) wr_a = {cur_a[16:2], i_addr[1:0]};
   always @(posedge i_we_n) if (sel && i_sleep_n) finish_wr();
   always @(posedge i_cs_n) if (sel && i_sleep_n) begin
      t_rise = $realtime;
      if (!i_we_n) finish_wr();
      else close_rd();
      sel = 1'b0;
      gen++;
      valid = 1'b0;
   end
   always @(negedge i_sleep_n) slept = 1'b1;
   always @(posedge i_sleep_n) if (slept) t_wake = $realtime;
   assign o_dq_oe = {2{valid && sel && i_we_n && !i_oe_n && i_sleep_n}} & ~{i_upper_sel_n, i_lower_sel_n};
endmodule
`default_nettype wire

// ===== verification/nvw_host_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module nvw_host_ctrl_bench import nvw_pkg::*; ();
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req = 1'b0;
   logic we = 1'b0;
   logic sleep = 1'b0;
   logic wp_req = 1'b0;
   logic [16:0] addr = 17'h00000;
   logic [15:0] wdata = 16'h0000;
   logic [1:0] be_n = 2'h0;
   logic [7:0] wp_byte = 8'h00;
   logic [7:0] sh_prot = 8'h00;
   logic [15:0] flt = 16'h5a5a;
   logic [15:0] dq, dq_o, dev_dq, rdata;
   logic [16:0] pin_a, cur, b0, b3;
   logic [1:0] dev_oe;
   logic ready, rvalid, wp_busy, cs_n, we_n, oe_n, upper_n, lower_n, sleep_n, dq_oe;
   logic [15:0] shadow [int];
   logic [31:0] exp_q [$];
   int viol;
   int errors = 0;
   int checked = 0;
   initial forever #5 clk = ~clk;
   // released lanes show a moving pattern, not the last value
   always @(posedge clk) flt <= flt + 16'h3b1d;
   assign dq[15:8] = dq_oe ? dq_o[15:8] : dev_oe[1] ? dev_dq[15:8] : flt[15:8];
   assign dq[7:0] = dq_oe ? dq_o[7:0] : dev_oe[0] ? dev_dq[7:0] : flt[7:0];
   nvw_host_ctrl dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_REQ(req), .I_WE(we), .I_ADDR(addr), .I_WDATA(wdata),
      .I_BE_N(be_n), .I_SLEEP(sleep), .I_WP_REQ(wp_req), .I_WP_BYTE(wp_byte), .I_DATA_LINES(dq),
      .O_READY(ready), .O_RVALID(rvalid), .O_RDATA(rdata), .O_WP_BUSY(wp_busy), .O_CHIP_SELECT_N(cs_n),
      .O_WRITE_STROBE_N(we_n), .O_OUTPUT_DRIVE_N(oe_n), .O_UPPER_BYTE_SEL_N(upper_n), .O_LOWER_BYTE_SEL_N(lower_n),
      .O_SLEEP_REQUEST_N(sleep_n), .O_ADDR(pin_a), .O_DATA_LINES_O(dq_o), .O_DATA_LINES_OE(dq_oe));
   nvw_dev_model dev_u (.i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_upper_sel_n(upper_n),
      .i_lower_sel_n(lower_n), .i_sleep_n(sleep_n), .i_addr(pin_a), .i_dq(dq), .o_dq(dev_dq), .o_dq_oe(dev_oe),
      .o_viol(viol));
   // ====================
   // shared tasks
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_val(ref logic s, input logic v, input int lim, input string what);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      check(what, {15'h0000, v}, {15'h0000, s});
   endtask
   task automatic do_req(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] be);
      logic [15:0] old;
      wait_val(ready, 1'b1, 100, "ready");
      req = 1'b1;
      we = w;
      addr = a;
      wdata = d;
      be_n = be;
      @(negedge clk);
      req = 1'b0;
      old = shadow.exists(a) ? shadow[a] : a[15:0] ^ 16'h5a5a;
      if (w && !sh_prot[a[16:14]]) shadow[a] = {be[1] ? old[15:8] : d[15:8], be[0] ? old[7:0] : d[7:0]};
      if (!w) exp_q.push_back({{be[1] ? 8'h00 : 8'hff, be[0] ? 8'h00 : 8'hff}, old});
   endtask
   always @(posedge clk) begin
      logic [31:0] e;
      check("bus contention", 16'h0000, {15'h0000, dq_oe & |dev_oe});
      if (rvalid === 1'b1 && exp_q.size() == 0) check("unexpected read", 16'h0000, 16'h0001);
      else if (rvalid === 1'b1) begin
         e = exp_q.pop_front();
         check("read data", e[15:0] & e[31:16], rdata & e[31:16]);
      end
   end
   // ====================
   // scenarios
   initial begin
      void'($urandom(32'hbcf928e2));
      repeat (2) @(negedge clk);
      check("select in reset", 16'h0001, {15'h0000, cs_n});
      check("ready in reset", 16'h0000, {15'h0000, ready});
      rstn = 1'b1;
      wait_val(ready, 1'b1, 2, "ready after reset");
      b0 = {5'h01, 10'($urandom), 2'h0};
      b3 = {5'h0d, 10'($urandom), 2'h0};
      for (int k = 0; k < 2; k++) begin
         cur = k ? b3 : b0;
         for (int i = 0; i < 4; i++) do_req(1'b1, cur + 17'(i), 16'($urandom), 2'h0);
         do_req(1'b1, cur + 17'h1, 16'($urandom), 2'h2);
         for (int i = 0; i < 4; i++) do_req(1'b0, cur + 17'(i), 16'h0000, 2'(i % 3));
         do_req(1'b0, cur ^ 17'h00100, 16'h0000, 2'h0);
         do_req(1'b0, cur + 17'h3, 16'h0000, 2'h0);
      end
      for (int p = 0; p < 2; p++) begin
         wait_val(ready, 1'b1, 100, "ready");
         wp_byte = p ? 8'h00 : 8'h18;
         // a level: the open row must close before the sequencer can start
         wp_req = 1'b1;
         wait_val(wp_busy, 1'b1, 40, "protect busy");
         wp_req = 1'b0;
         wait_val(wp_busy, 1'b0, 1000, "protect done");
         sh_prot = wp_byte;
         do_req(1'b1, b3, 16'($urandom), 2'h0);
         do_req(1'b1, b0, 16'($urandom), 2'h0);
         do_req(1'b0, b3, 16'h0000, 2'h0);
         do_req(1'b0, b0, 16'h0000, 2'h0);
      end
      wait_val(ready, 1'b1, 100, "ready");
      sleep = 1'b1;
      wait_val(sleep_n, 1'b0, 40, "sleep pin");
      check("ready asleep", 16'h0000, {15'h0000, ready});
      repeat (5) @(negedge clk);
      sleep = 1'b0;
      wait_val(sleep_n, 1'b1, 5, "wake pin");
      for (int i = 0; i < 6; i++) do_req(1'b0, 17'($urandom), 16'h0000, 2'($urandom));
      wait_val(ready, 1'b1, 100, "ready");
      repeat (12) @(negedge clk);
      check("reads left", 16'h0000, 16'(exp_q.size()));
      check("pin timing faults", 16'h0000, 16'(viol));
      give_verdict();
   end
   // generous bound: the whole run needs about a thousand cycles
   initial begin
      #(20000 * CLK_PERIOD_NS);
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
